//--- hdl/sbps_top.sv
// Purpose: batch and contact stroke generation behind an AXI4-Lite slave
// Assumes: pins are asynchronous and pass two flip-flops before use
// Notes:   one stroke pulse per rate tick; the rate register is mode independent
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns

module sbps_top (
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        ext_pin,
    input  wire logic                        stop_key,
    input  wire logic                        push_key,
    input  wire logic                        pause_pin,
    input  wire logic                        s_axi_awvalid,
    output wire logic                        s_axi_awready,
    input  wire logic [sbps_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_wvalid,
    output wire logic                        s_axi_wready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    output wire logic                        s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    output wire logic [1:0]                  s_axi_bresp,
    input  wire logic                        s_axi_arvalid,
    output wire logic                        s_axi_arready,
    input  wire logic [sbps_pkg::ADDR_W-1:0] s_axi_araddr,
    output wire logic                        s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output wire logic [31:0]                 s_axi_rdata,
    output wire logic [1:0]                  s_axi_rresp,
    output wire logic                        stroke,
    output wire logic                        fault,
    output wire logic                        running,
    output wire logic                        irq
);
    import sbps_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]        ext_s;
        logic [2:0]        stop_s;
        logic [2:0]        push_s;
        logic [2:0]        pause_s;
        logic              awready;
        logic              wready;
        logic              aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic              w_held;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        sbps_mode_e        mode;
        logic              mem_en;
        logic              push_sel;
        logic [CNT_W-1:0]  batch;
        logic [FAC_W-1:0]  factor;
        logic [31:0]       period;
        logic [31:0]       timer;
        logic [CNT_W-1:0]  pending;
        logic [31:0]       total;
        logic              running;
        logic              fault;
        logic              stroke;
        logic [EV_W-1:0]   istat;
        logic [EV_W-1:0]   imask;
        logic              irq;
    } sbps_top_s;

    sbps_top_s st;
    sbps_top_s next_st;
    logic      clr_any;

    sbps_scale_if sc ();

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // bounds a written value into its legal range
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        if (v < lo) begin
            return lo;
        end
        if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // scaler keeps the fractional remainder between pulses
    sbps_scaler u_scaler (
        .clk  (clk),
        .rstn (rstn),
        .sc   (sc.scl)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // bus, key events, memory and stroke timing all in one pass
    always_comb begin
        logic             ext_ev;
        logic             ss_ev;
        logic             push_ev;
        logic             pause_ev;
        logic             paused;
        logic             clr_cmd;
        logic             tick;
        logic             dec;
        logic [CNT_W-1:0] add;
        logic [CNT_W:0]   sum;
        logic [31:0]      wv;
        logic [EV_W-1:0]  ev;
        logic [EV_W-1:0]  w1c;
        ext_ev   = 1'b0;
        ss_ev    = 1'b0;
        push_ev  = 1'b0;
        pause_ev = 1'b0;
        paused   = 1'b0;
        clr_cmd  = 1'b0;
        tick     = 1'b0;
        dec      = 1'b0;
        add      = '0;
        sum      = '0;
        wv       = '0;
        ev       = '0;
        w1c      = '0;
        next_st  = st;
        next_st.stroke = 1'b0;

        // two-stage synchronisers, edges taken after the second stage
        next_st.ext_s   = {st.ext_s[1:0], ext_pin};
        next_st.stop_s  = {st.stop_s[1:0], stop_key};
        next_st.push_s  = {st.push_s[1:0], push_key};
        next_st.pause_s = {st.pause_s[1:0], pause_pin};
        ext_ev   = st.ext_s[1] & ~st.ext_s[2];
        ss_ev    = st.stop_s[1] & ~st.stop_s[2];
        push_ev  = st.push_s[1] & ~st.push_s[2];
        pause_ev = st.pause_s[1] & ~st.pause_s[2];
        paused   = st.pause_s[1];

        // write channel: address and data held until both are in
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = RESP_OKAY;
            case (st.awaddr)
                OFF_CTRL: begin
                    wv = merge({28'h0, st.push_sel, st.mem_en, st.mode},
                               st.wdata, st.wstrb);
                    // an unused mode code keeps the old mode
                    if (wv[1:0] <= 2'(SB_CONTACT)) begin
                        next_st.mode = sbps_mode_e'(wv[1:0]);
                    end
                    next_st.mem_en   = wv[CTRL_MEM];
                    next_st.push_sel = wv[CTRL_PUSH];
                end
                OFF_BATCH: begin
                    wv = merge(32'(st.batch), st.wdata, st.wstrb);
                    next_st.batch = CNT_W'(clamp(wv, 32'(MIN_STROKE),
                                                 32'(MAX_STROKE)));
                end
                OFF_FACTOR: begin
                    wv = merge(32'(st.factor), st.wdata, st.wstrb);
                    next_st.factor = FAC_W'(clamp(wv, 32'(FAC_MIN),
                                                  32'(FAC_MAX)));
                end
                OFF_PERIOD: begin
                    wv = merge(st.period, st.wdata, st.wstrb);
                    next_st.period = clamp(wv, 32'h1, 32'hFFFFFFFF);
                end
                OFF_CMD: begin
                    wv = merge(32'h0, st.wdata, st.wstrb);
                    clr_cmd = wv[CMD_CLR];
                    ss_ev   = ss_ev | wv[CMD_SS];
                    push_ev = push_ev | wv[CMD_PUSH];
                end
                OFF_ISTAT: begin
                    wv  = merge(32'h0, st.wdata, st.wstrb);
                    w1c = wv[EV_W-1:0];
                end
                OFF_IMASK: begin
                    wv = merge(32'(st.imask), st.wdata, st.wstrb);
                    next_st.imask = wv[EV_W-1:0];
                end
                OFF_STATUS, OFF_PENDING, OFF_TOTAL: begin
                    wv = '0;
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;

        // read channel: data one cycle after the address is taken
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                OFF_CTRL:    next_st.rdata = {28'h0, st.push_sel, st.mem_en, st.mode};
                OFF_BATCH:   next_st.rdata = 32'(st.batch);
                OFF_FACTOR:  next_st.rdata = 32'(st.factor);
                OFF_PERIOD:  next_st.rdata = st.period;
                OFF_CMD:     next_st.rdata = '0;
                OFF_STATUS:  next_st.rdata = {29'h0, paused, st.fault, st.running};
                OFF_PENDING: next_st.rdata = 32'(st.pending);
                OFF_TOTAL:   next_st.rdata = st.total;
                OFF_ISTAT:   next_st.rdata = 32'(st.istat);
                OFF_IMASK:   next_st.rdata = 32'(st.imask);
                default: begin
                    next_st.rdata = '0;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        next_st.arready = !next_st.rvalid;

        // rate divider gives a one-cycle stroke opportunity; blocked by fault
        if (st.running && !paused && !st.fault) begin
            if (st.timer >= st.period - 32'h1) begin
                next_st.timer = '0;
                tick = 1'b1;
            end else begin
                next_st.timer = st.timer + 32'h1;
            end
        end
        if (tick && (st.mode == SB_MANUAL || st.pending != '0)) begin
            next_st.stroke = 1'b1;
            next_st.total  = st.total + 32'h1;
            dec = (st.mode != SB_MANUAL);
        end

        // stroke demand: batch preset or scaler credits
        if (st.running && !st.fault) begin
            if (st.mode == SB_BATCH &&
                ((push_ev && st.push_sel) || ext_ev)) begin
                add = st.batch;
            end
            if (st.mode == SB_CONTACT && sc.credit) begin
                add = CNT_W'(1);
            end
        end
        if (st.mode == SB_BATCH && dec && st.pending == CNT_W'(1) && add == '0) begin
            ev[EV_DONE] = 1'b1;
        end
        ev[EV_PULSE] = ext_ev;

        // without memory a new demand is dropped while strokes are owed
        sum = (CNT_W+1)'(st.pending) - (CNT_W+1)'(dec);
        if (add != '0 && (st.mem_en || st.pending == '0)) begin
            sum = sum + (CNT_W+1)'(add);
        end
        if (sum > (CNT_W+1)'(MAX_STROKE)) begin
            next_st.fault   = 1'b1;
            next_st.pending = '0;
            ev[EV_OVF]      = 1'b1;
        end else begin
            next_st.pending = CNT_W'(sum);
        end

        // clears win over new demand in the same cycle
        clr_any = ss_ev || pause_ev || clr_cmd;
        if (clr_any) begin
            next_st.pending = '0;
        end
        if (clr_cmd) begin
            next_st.total = '0;
        end
        if (ss_ev) begin
            next_st.running = !st.running;
            next_st.fault   = 1'b0;
            next_st.timer   = '0;
        end

        // sticky events: a set in the clearing cycle survives
        next_st.istat = (st.istat & ~w1c) | ev;
        next_st.irq   = |(next_st.istat & next_st.imask);
    end

    // scaler fed only in contact mode while strokes are allowed
    assign sc.pulse  = st.ext_s[1] & ~st.ext_s[2] & (st.mode == SB_CONTACT)
                       & st.running & ~st.fault & ~st.pause_s[1];
    assign sc.clear  = clr_any;
    assign sc.factor = st.factor;

    // ------------------------------------------------------------------
    // registers and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st          <= '0;
            st.awready  <= 1'b1;
            st.wready   <= 1'b1;
            st.arready  <= 1'b1;
            st.mode     <= SB_MANUAL;
            st.batch    <= BATCH_RST;
            st.factor   <= FAC_ONE;
            st.period   <= PERIOD_RST;
            st.running  <= RUN_RST;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign stroke        = st.stroke;
    assign fault         = st.fault;
    assign running       = st.running;
    assign irq           = st.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_batch_range: assert property (
        st.batch >= MIN_STROKE && st.batch <= MAX_STROKE)
        else $error("batch preset out of range");
    a_batch_start: assert property (
        (st.mode == SB_BATCH && st.running && !st.fault && st.pending == '0
         && $rose(st.ext_s[1]) && !$past(st.ext_s[1]) && !clr_any)
        |=> st.pending == $past(st.batch))
        else $error("external pulse did not load a batch");
    a_pend_cap: assert property (st.pending <= MAX_STROKE)
        else $error("stroke memory above capacity");
    a_ovf_fault: assert property ($rose(st.fault)
        |-> st.istat[EV_OVF] && st.pending == '0)
        else $error("fault without overflow event");
    a_mem_clear: assert property (clr_any |=> st.pending == '0)
        else $error("stroke memory not cleared");
    a_rate_kept: assert property ($changed(st.mode) |-> $stable(st.period))
        else $error("stroke rate changed with mode");
    a_contact_src: assert property (
        (st.mode == SB_CONTACT && $stable(st.mode)
         && st.pending > $past(st.pending)) |-> $past(sc.credit))
        else $error("contact stroke without pulse credit");
    a_factor_range: assert property (
        st.factor >= FAC_MIN && st.factor <= FAC_MAX)
        else $error("factor out of range");
    a_fault_block: assert property (st.fault |=> !st.stroke)
        else $error("stroke issued in fault");

    c_batch_run:  cover property (st.mode == SB_BATCH && st.istat[EV_DONE]);
    c_overflow:   cover property ($rose(st.fault));
    c_credit:     cover property (st.mode == SB_CONTACT && sc.credit ##[1:50] st.stroke);
    c_stop_start: cover property ($fell(st.running) ##[1:20] $rose(st.running));
endmodule

//--- hdl/sbps_pkg.sv
// Purpose: shared constants and types for the stroke batch and pulse scaler
// Assumes: 125 MHz clock, AXI4-Lite register access with 32-bit data
// Notes:   factors and remainders are held in hundredths of a stroke

package sbps_pkg;

    // ------------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------------
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_BATCH   = 8'h04;
    localparam logic [7:0] OFF_FACTOR  = 8'h08;
    localparam logic [7:0] OFF_PERIOD  = 8'h0C;
    localparam logic [7:0] OFF_CMD     = 8'h10;
    localparam logic [7:0] OFF_STATUS  = 8'h14;
    localparam logic [7:0] OFF_PENDING = 8'h18;
    localparam logic [7:0] OFF_TOTAL   = 8'h1C;
    localparam logic [7:0] OFF_ISTAT   = 8'h20;
    localparam logic [7:0] OFF_IMASK   = 8'h24;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MEM  = 2;
    localparam int CTRL_PUSH = 3;
    localparam int CMD_CLR   = 0;
    localparam int CMD_SS    = 1;
    localparam int CMD_PUSH  = 2;
    localparam int EV_DONE   = 0;
    localparam int EV_OVF    = 1;
    localparam int EV_PULSE  = 2;
    localparam int EV_W      = 3;

    // ------------------------------------------------------------------
    // widths, limits and reset values
    // ------------------------------------------------------------------
    localparam int          CNT_W      = 17;
    localparam int          FAC_W      = 14;
    localparam int          ACC_W      = 24;
    localparam logic [16:0] MAX_STROKE = 17'h1869F;
    localparam logic [16:0] MIN_STROKE = 17'h00001;
    localparam logic [13:0] FAC_MIN    = 14'h0001;
    localparam logic [13:0] FAC_MAX    = 14'h270F;
    localparam logic [13:0] FAC_ONE    = 14'h0064;
    localparam logic [16:0] BATCH_RST  = 17'h00001;
    localparam logic [31:0] PERIOD_RST = 32'h000030D4;
    localparam logic        RUN_RST    = 1'b1;

    typedef enum logic [1:0] {SB_MANUAL, SB_BATCH, SB_CONTACT} sbps_mode_e;

endpackage

//--- hdl/sbps_scale_if.sv
// Purpose: carries pulses and factor to the scaler, stroke credits back
// Assumes: both ends on the same clock
// Notes:   pulse, clear and credit are one-cycle strobes
`timescale 1ns/1ns

interface sbps_scale_if;
    logic                     pulse;
    logic                     clear;
    logic [sbps_pkg::FAC_W-1:0] factor;
    logic                     credit;

    modport ctl (output pulse, output clear, output factor, input credit);
    modport scl (input pulse, input clear, input factor, output credit);
endinterface

//--- hdl/sbps_scaler.sv
// Purpose: turns scaled pulses into single stroke credits
// Assumes: factor held in hundredths, between one hundredth and 99.99
// Notes:   drains one credit per cycle; very fast pulse bursts deepen the sum
`timescale 1ns/1ns

module sbps_scaler (
    input wire logic clk,
    input wire logic rstn,
    sbps_scale_if.scl sc
);
    import sbps_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic             credit;
    } sbps_scl_s;

    sbps_scl_s st;
    sbps_scl_s next_st;

    // ------------------------------------------------------------------
    // remainder accumulator
    // ------------------------------------------------------------------
    // integer hundredths keep the average exact, no rounding drift
    always_comb begin
        logic [ACC_W-1:0] sum;
        sum = '0;
        next_st = st;
        sum = st.acc + (sc.pulse ? ACC_W'(sc.factor) : '0);
        next_st.credit = 1'b0;
        if (sum >= ACC_W'(FAC_ONE)) begin
            next_st.credit = 1'b1;
            sum = sum - ACC_W'(FAC_ONE);
        end
        next_st.acc = sum;
        if (sc.clear) begin
            next_st.acc = '0;
            next_st.credit = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sc.credit = st.credit;

    a_carry_step: assert property (@(posedge clk) disable iff (!rstn)
        ($past(!sc.pulse && !sc.clear) && st.credit)
            |-> st.acc == $past(st.acc) - ACC_W'(FAC_ONE))
        else $error("carry did not remove one whole stroke");
endmodule

//--- test/sbps_src.sv
// Purpose: model of the external pulse source and operator keys
// Assumes: pins held two cycles, so the design's synchroniser sees them
// Notes:   index 0 ext pulse, 1 stop/start, 2 push, 3 pause
`timescale 1ns/1ns
module sbps_src (
    input  wire logic clk,
    output wire logic ext_pin,
    output wire logic stop_key,
    output wire logic push_key,
    output wire logic pause_pin
);
    logic [3:0] p = 4'h0;
    assign {pause_pin, push_key, stop_key, ext_pin} = p;
    // six-cycle spacing keeps back-to-back triggers distinct
    task press(input int k, input int n);
        repeat (n) begin
            p[k] <= 1'h1;
            repeat (2) @(posedge clk);
            p[k] <= 1'h0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

//--- test/sbps_top_tb.sv
// Purpose: register-level tests of batch and contact stroke generation
// Assumes: stroke period shortened through its register
// Notes:   strokes are tallied by the bench; the total register is read back only as zero after a clear
`timescale 1ns/1ns
module sbps_top_tb;
    import sbps_pkg::*;
    logic        clk = 1'h0, rstn = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  rr;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic   stroke, fault, running, irq, ext_pin, stop_key, push_key, pause_pin;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int err_total = 0, n_checks = 0, nstk = 0, cyc = 0, b;
    int fac[3] = '{150, 25, 40};
    int np[3] = '{4, 8, 5};
    int ex[3] = '{6, 2, 2};
    sbps_top u_sbps_top (.*);
    sbps_src u_sbps_src (.*);
    initial forever #4 clk = ~clk;
    // own stroke tally and hang guard
    always @(posedge clk) begin
        cyc++;
        if (stroke === 1'h1) nstk++;
        if (cyc == 60000) begin
            err_total++;
            conclude;
        end
    end
    task conclude;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // each channel released at its own handshake edge
    task wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge clk);
    endtask
    task chk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        cmp(d, e);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        chk(OFF_BATCH, 1);
        chk(OFF_FACTOR, 100);
        rd(8'h40);
        cmp(rr, RESP_SLVERR);
        wr(8'h40, 0);
        cmp(rr, RESP_SLVERR);
        wr(OFF_BATCH, 0);
        chk(OFF_BATCH, 1);
        wr(OFF_BATCH, 100000);
        chk(OFF_BATCH, 99999);
        wr(OFF_FACTOR, 0);
        chk(OFF_FACTOR, 1);
        wr(OFF_FACTOR, 10000);
        chk(OFF_FACTOR, 9999);
        // contact mode, step-up and step-down factors, memory on
        wr(OFF_CTRL, 6);
        chk(OFF_PERIOD, PERIOD_RST);
        wr(OFF_PERIOD, 4);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_FACTOR, fac[i]);
            wr(OFF_CMD, 1);
            b = nstk;
            u_sbps_src.press(0, np[i]);
            repeat (100) @(posedge clk);
            cmp(nstk - b, ex[i]);
        end
        // batch by push key, then by external pulse
        wr(OFF_CTRL, 9);
        wr(OFF_BATCH, 3);
        wr(OFF_IMASK, 1);
        b = nstk;
        u_sbps_src.press(2, 1);
        repeat (60) @(posedge clk);
        cmp(irq, 1);
        wr(OFF_ISTAT, 1);
        cmp(irq, 0);
        u_sbps_src.press(0, 1);
        repeat (60) @(posedge clk);
        cmp(nstk - b, 6);
        wr(OFF_CTRL, 1);
        u_sbps_src.press(2, 1);
        wr(OFF_CMD, 4);
        repeat (60) @(posedge clk);
        cmp(nstk - b, 6);
        // memory overflow, then stop/start recovery
        wr(OFF_CTRL, 5);
        wr(OFF_PERIOD, 1000);
        wr(OFF_BATCH, 99999);
        u_sbps_src.press(0, 2);
        repeat (10) @(posedge clk);
        cmp(fault, 1);
        b = nstk;
        repeat (2100) @(posedge clk);
        cmp(nstk - b, 0);
        u_sbps_src.press(1, 1);
        cmp(fault, 0);
        cmp(running, 0);
        chk(OFF_PENDING, 0);
        u_sbps_src.press(1, 1);
        // pause and clear counters empty the memory
        wr(OFF_BATCH, 50);
        u_sbps_src.press(0, 1);
        u_sbps_src.press(3, 1);
        chk(OFF_PENDING, 0);
        u_sbps_src.press(0, 1);
        wr(OFF_CMD, 1);
        chk(OFF_PENDING, 0);
        chk(OFF_TOTAL, 0);
        // stop/start through the command register while strokes are owed
        u_sbps_src.press(0, 1);
        wr(OFF_CMD, 2);
        chk(OFF_PENDING, 0);
        cmp(running, 0);
        conclude;
    end
endmodule
